// file: verilog/pocd_defines.svh
// Purpose: Offsets, field positions and reset values for the port protection block.
// Assumes: 8-bit register port, registers at byte offsets.
// Notes:   Definitions only.
`ifndef POCD_DEFINES_SVH
`define POCD_DEFINES_SVH

`define POCD_ADDR_W        4
`define POCD_DATA_W        8
`define POCD_OFF_CTRL      4'h0
`define POCD_OFF_DRIVE     4'h1
`define POCD_OFF_OC_EN     4'h2
`define POCD_OFF_OC_FLAG   4'h3
`define POCD_OFF_OC_IRQEN  4'h4
`define POCD_OFF_HV_CTRL   4'h5
`define POCD_OFF_HV_LEVEL  4'h6
`define POCD_OFF_HV_FLAG   4'h7
`define POCD_OFF_HV_IRQEN  4'h8
`define POCD_NUM_PINS      4
`define POCD_CTRL_RST      8'h00
`define POCD_DRIVE_RST     4'h0
`define POCD_OC_EN_RST     4'h0
`define POCD_OC_IRQEN_RST  4'h0
`define POCD_HV_CTRL_RST   8'h00
`define POCD_HV_IRQEN_RST  1'h0
`define POCD_HV_AEN_BIT    0
`define POCD_HV_DIR_BIT    1
`define POCD_HV_PS_BIT     2
`define POCD_HV_FORCE_BIT  3
`define POCD_HV_DIEN_BIT   4

`endif

// file: verilog/pocd_pkg.sv
// Purpose: Types shared by the port protection block.
// Assumes: Header pocd_defines.svh supplies the constants.
// Notes:   Pin 0 is the switched supply pin, pins 1 to 3 the switched ground pins.
`include "pocd_defines.svh"

package pocd_pkg;

	typedef struct packed {
		logic [`POCD_ADDR_W-1:0] addr;
		logic [`POCD_DATA_W-1:0] wdata;
		logic                    wr;
		logic                    rd;
	} pocd_bus_s;

	typedef struct packed {
		logic aen;
		logic dir;
		logic pull_sel;
		logic buf_force;
		logic dien;
	} pocd_hv_cfg_s;

	typedef enum logic [1:0] {
		POCD_MODE_RUN,
		POCD_MODE_WAIT,
		POCD_MODE_STOP
	} pocd_mode_e;

endpackage : pocd_pkg

// file: verilog/pocd_sync.sv
// Purpose: Two-flop synchroniser for a group of levels.
// Assumes: Inputs are asynchronous to clock_i.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/10ps

module pocd_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset.
	input  wire logic             clock_i,
	input  wire logic             rstn_i,
	input  wire logic             clk_en_i,
	// Data.
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] stage1;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			stage1 <= '0;
			sync_o <= '0;
		end else if (clk_en_i) begin
			stage1 <= async_i;
			sync_o <= stage1;
		end
	end

endmodule : pocd_sync

// file: verilog/pocd_hv_input.sv
// Purpose: Buffer enable and pull selection of the high-voltage input.
// Assumes: Configuration comes from the register file.
// Notes:   Combinational; the level is synchronised by the caller.
`timescale 1ns/10ps

module pocd_hv_input (
	// Configuration.
	input  pocd_pkg::pocd_hv_cfg_s cfg_i,
	input  pocd_pkg::pocd_mode_e   mode_i,
	// Analog controls towards the pad.
	output logic                   pullup_en_o,
	output logic                   pulldown_en_o,
	output logic                   buf_en_o
);
	import pocd_pkg::*;

	always_comb begin
		pullup_en_o   = cfg_i.pull_sel;  // RULE10
		pulldown_en_o = !cfg_i.pull_sel; // RULE10
		if (mode_i == POCD_MODE_STOP) begin
			buf_en_o = cfg_i.dien;
		end else if (cfg_i.aen) begin
			buf_en_o = cfg_i.buf_force && !cfg_i.dir; // RULE15 RULE11
		end else begin
			buf_en_o = cfg_i.dien;
		end
	end

endmodule : pocd_hv_input

// file: verilog/pocd_top.sv
// Purpose: Over-current protection for four switched pins and open-input check on the
//          high-voltage input, with a byte-wide register port and one interrupt.
// Assumes: Pin and mode inputs synchronous except the monitor trip lines.
// Notes:   Pin 0 sources (switched supply), pins 1 to 3 sink (switched grounds).
// Notes on behaviour
// RULE1: A monitor is powered only while its enable bit is set.
// RULE2: Monitors are off in stop mode.
// RULE3: Detection applies only to outputs at full drive.
// RULE4: Supply pin is protected only while driving high.
// RULE5: Supply pin trip in run mode forces it low and sets its flag.
// RULE6: Events are taken only in run mode from the comparator indication.
// RULE7: Ground pins protect while driving low and are forced high.
// RULE8: Software drives the supply pin low before stop mode.
// RULE9: Software starts the check with analog on and direct mode off.
// RULE10: Pull select one picks the pullup, zero the divider pulldown.
// RULE11: Override in analog non-direct mode keeps the input buffer on; in stop mode the code follows the dien bit instead.
// RULE12: Pullup and forced buffer: external pulldown reads 0, open reads 1.
// RULE13: Pulldown and forced buffer: external pullup reads 1, open reads 0.
// RULE14: Software clears the override after the check.
// RULE15: Analog mode turns the buffer off unless override set, direct clear; in stop mode the code follows the dien bit instead.
// RULE16: Input level register returns the synchronised pin state.
// RULE17: Set flag with its enable bit raises the interrupt.
// RULE18: Safe level holds while the flag is set.
// RULE19: Trip indications pass a two-flop synchroniser first.
`timescale 1ns/10ps
`include "pocd_defines.svh"

module pocd_top (
	// Clock and reset.
	input  wire logic                        clock_i,
	input  wire logic                        rstn_i,
	input  wire logic                        clk_en_i,
	// Register port.
	input  pocd_pkg::pocd_bus_s              bus_i,
	output logic            [`POCD_DATA_W-1:0] rdata_o,
	// Power mode.
	input  pocd_pkg::pocd_mode_e             mode_i,
	// Protected pins.
	input  wire logic [`POCD_NUM_PINS-1:0]   pin_data_i,
	input  wire logic [`POCD_NUM_PINS-1:0]   pin_dir_out_i,
	input  wire logic [`POCD_NUM_PINS-1:0]   oc_trip_i,
	output logic      [`POCD_NUM_PINS-1:0]   pin_o,
	output logic      [`POCD_NUM_PINS-1:0]   pin_oe_o,
	output logic      [`POCD_NUM_PINS-1:0]   overcurrent_monitor_power_o,
	// High-voltage input.
	input  wire logic                        hv_input_i,
	output logic                             hv_pullup_en_o,
	output logic                             hv_pulldown_en_o,
	output logic                             hv_buf_en_o,
	// Interrupt.
	output logic                             irq_o
);
	import pocd_pkg::*;

	localparam int N = `POCD_NUM_PINS;

	// ==========================================================
	// Registers
	// ==========================================================
	logic [N-1:0]        full_drive;
	logic [N-1:0]        overcurrent_monitor_enable;
	logic [N-1:0]        overcurrent_flag;
	logic [N-1:0]        overcurrent_irq_enable;
	logic [7:0]          hv_analog_control;
	logic                hv_flag;
	logic                hv_irq_enable;
	logic [N-1:0]        trip_sync;
	logic                hv_input_level;
	logic                hv_level_d;
	logic [N-1:0]        oc_event;
	logic [N-1:0]        active_dir;
	pocd_hv_cfg_s        hv_cfg;

	function automatic logic hit(input logic [`POCD_ADDR_W-1:0] off);
		hit = (bus_i.addr == off);
	endfunction : hit

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			full_drive                 <= `POCD_DRIVE_RST;
			overcurrent_monitor_enable <= `POCD_OC_EN_RST;
			overcurrent_irq_enable     <= `POCD_OC_IRQEN_RST;
			hv_analog_control          <= `POCD_HV_CTRL_RST;
			hv_irq_enable              <= `POCD_HV_IRQEN_RST;
		end else if (clk_en_i && bus_i.wr) begin
			if (hit(`POCD_OFF_DRIVE))
				full_drive <= bus_i.wdata[N-1:0];
			if (hit(`POCD_OFF_OC_EN))
				overcurrent_monitor_enable <= bus_i.wdata[N-1:0];
			if (hit(`POCD_OFF_OC_IRQEN))
				overcurrent_irq_enable <= bus_i.wdata[N-1:0];
			if (hit(`POCD_OFF_HV_CTRL))
				hv_analog_control <= bus_i.wdata;
			if (hit(`POCD_OFF_HV_IRQEN))
				hv_irq_enable <= bus_i.wdata[0];
		end
	end

	assign hv_cfg.aen       = hv_analog_control[`POCD_HV_AEN_BIT];
	assign hv_cfg.dir       = hv_analog_control[`POCD_HV_DIR_BIT];
	assign hv_cfg.pull_sel  = hv_analog_control[`POCD_HV_PS_BIT];
	assign hv_cfg.buf_force = hv_analog_control[`POCD_HV_FORCE_BIT];
	assign hv_cfg.dien      = hv_analog_control[`POCD_HV_DIEN_BIT];

	// ==========================================================
	// Over-current detection
	// ==========================================================
	pocd_sync #(
		.WIDTH (N)
	) u_trip_sync (
		.clock_i  (clock_i),
		.rstn_i   (rstn_i),
		.clk_en_i (clk_en_i),
		.async_i  (oc_trip_i),
		.sync_o   (trip_sync) // RULE19
	);

	// Pin 0 sources current when high; the grounds sink when low.
	assign active_dir = {~pin_data_i[N-1:1], pin_data_i[0]}; // RULE4 RULE7

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_pin
			// Monitor powered only when enabled and out of stop; full drive gates only the event.
			assign overcurrent_monitor_power_o[g] = overcurrent_monitor_enable[g]
				&& (mode_i != POCD_MODE_STOP); // RULE1 RULE2
			assign oc_event[g] = overcurrent_monitor_power_o[g]
				&& (mode_i == POCD_MODE_RUN) // RULE6
				&& pin_dir_out_i[g] && full_drive[g] // RULE3
				&& active_dir[g] && trip_sync[g]; // RULE4 RULE7

			// Flag set wins over a clear in the same cycle.
			always_ff @(posedge clock_i or negedge rstn_i) begin
				if (!rstn_i) begin
					overcurrent_flag[g] <= 1'b0;
				end else if (clk_en_i) begin
					if (oc_event[g])
						overcurrent_flag[g] <= 1'b1; // RULE5 RULE7
					else if (bus_i.wr && hit(`POCD_OFF_OC_FLAG) && bus_i.wdata[g])
						overcurrent_flag[g] <= 1'b0; // RULE18
				end
			end

			// Safe level: supply forced low, grounds forced high.
			always_comb begin
				pin_oe_o[g] = pin_dir_out_i[g];
				if (overcurrent_flag[g] || oc_event[g])
					pin_o[g] = (g != 0); // RULE5 RULE7 RULE18
				else
					pin_o[g] = pin_data_i[g];
			end

			a_flag_forces_safe : assert property (@(posedge clock_i) disable iff (!rstn_i)
				overcurrent_flag[g] |-> (pin_o[g] == (g != 0))) // RULE18
				else $error("pin not at safe level while flag set");
			a_no_trip_in_stop : assert property (@(posedge clock_i) disable iff (!rstn_i)
				(mode_i == POCD_MODE_STOP) |-> !oc_event[g]) // RULE2
				else $error("over-current event taken in stop mode");
			a_event_sets_flag : assert property (@(posedge clock_i) disable iff (!rstn_i)
				(clk_en_i && oc_event[g]) |=> overcurrent_flag[g]) // RULE5
				else $error("flag not set after over-current event");
			a_disabled_monitor : assert property (@(posedge clock_i) disable iff (!rstn_i)
				!overcurrent_monitor_enable[g] |-> !oc_event[g]) // RULE1
				else $error("event from a disabled monitor");
			a_reduced_drive : assert property (@(posedge clock_i) disable iff (!rstn_i)
				!full_drive[g] |-> !oc_event[g]) // RULE3
				else $error("event at reduced drive");
			a_trip_synced : assert property (@(posedge clock_i) disable iff (!rstn_i)
				oc_event[g] |-> $past(oc_trip_i[g], 2)) // RULE19
				else $error("event without synchronised trip");
		end
	endgenerate

	a_supply_dir_only : assert property (@(posedge clock_i) disable iff (!rstn_i)
		!pin_data_i[0] |-> !oc_event[0]) // RULE4
		else $error("supply pin event while driving low");
	a_ground_dir_only : assert property (@(posedge clock_i) disable iff (!rstn_i)
		pin_data_i[1] |-> !oc_event[1]) // RULE7
		else $error("ground pin event while driving high");

	// ==========================================================
	// High-voltage input
	// ==========================================================
	pocd_hv_input u_hv (
		.cfg_i         (hv_cfg),
		.mode_i        (mode_i),
		.pullup_en_o   (hv_pullup_en_o),
		.pulldown_en_o (hv_pulldown_en_o),
		.buf_en_o      (hv_buf_en_o)
	);

	// Pad level holds its internal pull when open; the buffer gates it to zero when off.
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hv_input_level <= 1'b0;
			hv_level_d     <= 1'b0;
		end else if (clk_en_i) begin
			hv_input_level <= hv_input_i && hv_buf_en_o; // RULE16 RULE12 RULE13
			hv_level_d     <= hv_input_level;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hv_flag <= 1'b0;
		end else if (clk_en_i) begin
			if (hv_input_level != hv_level_d)
				hv_flag <= 1'b1;
			else if (bus_i.wr && hit(`POCD_OFF_HV_FLAG) && bus_i.wdata[0])
				hv_flag <= 1'b0;
		end
	end

	a_buf_override : assert property (@(posedge clock_i) disable iff (!rstn_i)
		(mode_i == POCD_MODE_RUN && hv_cfg.aen) |->
			(hv_buf_en_o == (hv_cfg.buf_force && !hv_cfg.dir))) // RULE15
		else $error("analog buffer enable wrong");
	a_pull_select : assert property (@(posedge clock_i) disable iff (!rstn_i)
		(hv_pullup_en_o == hv_analog_control[`POCD_HV_PS_BIT])
			&& (hv_pullup_en_o != hv_pulldown_en_o)) // RULE10
		else $error("pullup and pulldown both or neither");

	// ==========================================================
	// Interrupt and read port
	// ==========================================================
	assign irq_o = |(overcurrent_flag & overcurrent_irq_enable)
		|| (hv_flag && hv_irq_enable); // RULE17

	a_irq_follows : assert property (@(posedge clock_i) disable iff (!rstn_i)
		|(overcurrent_flag & overcurrent_irq_enable) |-> irq_o) // RULE17
		else $error("interrupt missing for enabled flag");

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_o <= '0;
		end else if (clk_en_i) begin
			rdata_o <= '0;
			if (bus_i.rd) begin
				unique case (bus_i.addr)
					`POCD_OFF_DRIVE:     rdata_o <= {4'h0, full_drive};
					`POCD_OFF_OC_EN:     rdata_o <= {4'h0, overcurrent_monitor_enable};
					`POCD_OFF_OC_FLAG:   rdata_o <= {4'h0, overcurrent_flag};
					`POCD_OFF_OC_IRQEN:  rdata_o <= {4'h0, overcurrent_irq_enable};
					`POCD_OFF_HV_CTRL:   rdata_o <= hv_analog_control;
					`POCD_OFF_HV_LEVEL:  rdata_o <= {7'h00, hv_input_level}; // RULE16
					`POCD_OFF_HV_FLAG:   rdata_o <= {7'h00, hv_flag};
					`POCD_OFF_HV_IRQEN:  rdata_o <= {7'h00, hv_irq_enable};
					default:             rdata_o <= '0;
				endcase
			end
		end
	end

endmodule : pocd_top

// file: dv/pocd_load_model.sv
// Purpose: External loads on the protected pins and pull devices on the hv input.
// Assumes: A comparator trips only while its monitor is powered.
// Notes:   A floating hv input toggles every cycle.
`timescale 1ns/10ps

module pocd_load_model (
	// Clock.
	input  wire logic       clock_i,
	// Protected pins.
	input  wire logic [3:0] pin_i,
	input  wire logic [3:0] oe_i,
	input  wire logic [3:0] power_i,
	input  wire logic [3:0] short_i,
	output logic      [3:0] trip_o,
	// High-voltage input.
	input  wire logic       pullup_en_i,
	input  wire logic       pulldown_en_i,
	input  wire logic [1:0] ext_pull_i,
	output logic            hv_o
);
	logic toggle = 1'b0;
	always @(posedge clock_i) toggle <= ~toggle;
	// A shorted load draws current only while its pin drives the active level.
	assign trip_o = power_i & short_i & oe_i & (pin_i ^ 4'he);
	// An external pull outweighs the weak internal one.
	assign hv_o = (ext_pull_i == 2'h1) ? 1'b1 : (ext_pull_i == 2'h2) ? 1'b0 :
		pullup_en_i ? 1'b1 : pulldown_en_i ? 1'b0 : toggle;
endmodule : pocd_load_model

// file: dv/pocd_tb_top.sv
// Purpose: Self-checking bench for the port protection block.
// Assumes: Offsets as in the register map of the block.
// Notes:   Expected pin levels and flags come from a small integer model.
`timescale 1ns/10ps

module pocd_tb_top;
	import pocd_pkg::*;
	logic       clock_i = 1'b0;
	logic       rstn_i  = 1'b0;
	pocd_bus_s  bus     = '0;
	pocd_mode_e mode    = POCD_MODE_RUN;
	logic [3:0] data    = 4'h0;
	logic [3:0] shrt    = 4'h0;
	logic [1:0] ext     = 2'h0;
	logic       clk_en  = 1'b1;
	logic [3:0] dir     = 4'hf;
	logic [3:0] trip, pin, oe, pwr;
	logic [7:0] rdata;
	logic       hv, pu, pd, buf_en, irq;
	int         bad_count = 0, samples_checked = 0, seed = 32'h5d4f;
	int         m_flag = 0, m_irqen = 0, k;

	always #5 clock_i = ~clock_i;

	pocd_top u_dut (
		.clock_i(clock_i), .rstn_i(rstn_i), .clk_en_i(clk_en), .bus_i(bus),
		.rdata_o(rdata), .mode_i(mode), .pin_data_i(data), .pin_dir_out_i(dir),
		.oc_trip_i(trip), .pin_o(pin), .pin_oe_o(oe), .overcurrent_monitor_power_o(pwr),
		.hv_input_i(hv), .hv_pullup_en_o(pu), .hv_pulldown_en_o(pd),
		.hv_buf_en_o(buf_en), .irq_o(irq));

	pocd_load_model u_load (
		.clock_i(clock_i), .pin_i(pin), .oe_i(oe), .power_i(pwr), .short_i(shrt),
		.trip_o(trip), .pullup_en_i(pu), .pulldown_en_i(pd), .ext_pull_i(ext), .hv_o(hv));

	// ==========================================================
	// Compare and bus tasks.
	task automatic chk_rd(input string nm, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_rd

	task automatic chk_pin(input string nm, input logic [3:0] e, input logic [3:0] g);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_pin

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock_i);
		bus.addr  <= a;
		bus.wdata <= d;
		bus.wr    <= 1'b1;
		@(posedge clock_i);
		bus.wr    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
		@(posedge clock_i);
		bus.addr <= a;
		bus.rd   <= 1'b1;
		@(posedge clock_i);
		bus.rd   <= 1'b0;
		#1 chk_rd(nm, e, rdata);
	endtask : rd

	// Pins, interrupt and flag register against the model.
	task automatic chk_model();
		logic [3:0] e;
		e = (data & ~m_flag[3:0]) | (m_flag[3:0] & 4'he);
		chk_pin("pin_o", e, pin);
		chk_pin("pin_oe_o", dir, oe);
		chk_pin("irq_o", {3'h0, |(m_flag & m_irqen)}, {3'h0, irq});
		rd(4'h3, m_flag[7:0], "overcurrent_flag");
	endtask : chk_model

	// Shorts one pin, checks, releases, checks the held level, then clears.
	task automatic trip_case(input int p, input logic [3:0] d, input pocd_mode_e md,
			input bit hit);
		@(posedge clock_i);
		data    <= d;
		mode    <= md;
		shrt[p] <= 1'b1;
		repeat (6) @(posedge clock_i);
		if (hit)
			m_flag = m_flag | (1 << p);
		#1 chk_model();
		@(posedge clock_i);
		shrt[p] <= 1'b0;
		repeat (4) @(posedge clock_i);
		#1 chk_model();
		wr(4'h3, 8'(1 << p));
		m_flag = 0;
		mode <= POCD_MODE_RUN;
		#1 chk_model();
	endtask : trip_case

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report

	// ==========================================================
	// Watchdog.
	initial begin
		#100000;
		bad_count++;
		final_report();
	end

	// ==========================================================
	// Main sequence.
	initial begin
		repeat (5) @(posedge clock_i);
		rstn_i <= 1'b1;
		for (k = 1; k < 9; k++)
			rd(k[3:0], 8'h00, "reset value");
		rd(4'hf, 8'h00, "unmapped");
		wr(4'h1, 8'h0f);
		wr(4'h2, 8'h0f);
		m_irqen = ($random(seed) & 32'he) | 1;
		wr(4'h4, 8'(m_irqen));
		rd(4'h4, 8'(m_irqen), "overcurrent_irq_enable");
		// A write while the clock enable is low must leave the register untouched.
		@(posedge clock_i);
		clk_en <= 1'b0;
		wr(4'h4, 8'h00);
		clk_en <= 1'b1;
		rd(4'h4, 8'(m_irqen), "frozen overcurrent_irq_enable");
		#1 chk_pin("monitor power", 4'hf, pwr);
		@(posedge clock_i);
		mode <= POCD_MODE_STOP;
		repeat (2) @(posedge clock_i);
		#1 chk_pin("monitor power", 4'h0, pwr);
		trip_case(0, 4'h1, POCD_MODE_RUN, 1);
		trip_case(0, 4'h0, POCD_MODE_RUN, 0);
		for (k = 1; k < 4; k++) begin
			trip_case(k, 4'h0, POCD_MODE_RUN, 1);
			trip_case(k, 4'hf, POCD_MODE_RUN, 0);
		end
		trip_case(0, 4'h1, POCD_MODE_WAIT, 0);
		wr(4'h1, 8'h0e);
		trip_case(0, 4'h1, POCD_MODE_RUN, 0);
		wr(4'h1, 8'h0f);
		rd(4'h1, 8'h0f, "full_drive");
		// A pin configured as input never trips.
		@(posedge clock_i);
		dir <= 4'he;
		trip_case(0, 4'h1, POCD_MODE_RUN, 0);
		@(posedge clock_i);
		dir <= 4'hf;
		wr(4'h2, 8'h0e);
		rd(4'h2, 8'h0e, "overcurrent_monitor_enable");
		trip_case(0, 4'h1, POCD_MODE_RUN, 0);
		// Open-input check: bit 0 picks the internal pull, bit 1 fits the opposite device.
		for (k = 0; k < 4; k++) begin
			@(posedge clock_i);
			ext <= k[1] ? (k[0] ? 2'h2 : 2'h1) : 2'h0;
			wr(4'h5, 8'h09 | {5'h00, k[0], 2'h0});
			repeat (3) @(posedge clock_i);
			#1 chk_pin("pulls", {2'h0, k[0], ~k[0]}, {2'h0, pu, pd});
			chk_pin("buf_en", 4'h1, {3'h0, buf_en});
			rd(4'h6, {7'h0, k[1] ^ k[0]}, "hv_input_level");
			wr(4'h5, 8'h01 | {5'h00, k[0], 2'h0});
			#1 chk_pin("buf_en", 4'h0, {3'h0, buf_en});
			rd(4'h6, 8'h00, "hv_input_level");
		end
		wr(4'h5, 8'h0b);
		#1 chk_pin("buf_en", 4'h0, {3'h0, buf_en});
		rd(4'h5, 8'h0b, "hv_analog_control");
		// The level rose twice during the check, so the change flag stands.
		rd(4'h7, 8'h01, "hv level flag");
		wr(4'h8, 8'h01);
		#1 chk_pin("irq_o", 4'h1, {3'h0, irq});
		wr(4'h7, 8'h01);
		#1 chk_pin("irq_o", 4'h0, {3'h0, irq});
		rd(4'h8, 8'h01, "hv irq enable");
		final_report();
	end
endmodule : pocd_tb_top
